// file: auto_scan_adc_serial_sequencer.sv
// serial command decoder and auto-scan conversion sequencer
// assumes: serial pins and the rc oscillator are asynchronous to ref_clk,
// conversion result comes from the comparator logic on ref_clk
//
// Summary of operation
// - mode code 1110 selects automatic scanning
// - twelve config bits follow, set pair muxing
// - two-input variant decodes three config LSBs
// - input sampled from first clock rise after select
// - bits after last config bit ignored
// - conversion starts one to two oscillator periods
// - end flag low converting, high when done
// - total scan time depends on pair configuration
// - output shifts only while select low
// - eight result bits then four status bits
// - result LSB first, status MSB first
// - output released after last status bit
// - select rise after output converts next pair
// - select high too briefly aborts, expects mode
// - select fall during conversion aborts it
// - mode 1100 locks test mode until power
// - output released on input, input ignored on output
// - conversion takes seventeen oscillator periods
// - differential: positive then negative, one period
// - result is unsigned 256-code value
`timescale 1ns/1ps
module auto_scan_adc_serial_sequencer #(
    parameter int NUM_PAIRS = 4
) (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst_b,
    // serial link pins
    input  wire logic                          serialClk,
    input  wire logic                          chipSel_b,
    input  wire logic                          serial_in,
    output logic                               serialOut,
    output logic                               serialOutEn,
    output logic                               endOfConv,
    // conversion oscillator pin
    input  wire logic                          conversion_oscillator,
    // converter core
    input  wire logic [scan_seq_pkg::RES_W-1:0]  convResult,
    output logic [scan_seq_pkg::STAT_W-1:0]      input_selector,
    output logic                               samplePos,
    output logic                               sampleNeg,
    // status
    output logic                               testModeLock
);
    import scan_seq_pkg::*;

    // ========================================================
    // elaboration checks; the pair pointer is two bits wide and the
    // decode only knows the one-pair and the four-pair variant
    if (NUM_PAIRS != 1 && NUM_PAIRS != MAX_PAIRS) begin : g_bad_pairs
        $error("NUM_PAIRS must be 1 or 4");
    end

    // ========================================================
    // pin synchronisers; stage 0 feeds only stage 1
    // clock-like pins keep a third stage as the edge reference;
    // the data pin needs only two, it is read on a found clock edge
    logic [2:0] sclkSync_r;
    logic [2:0] csSync_r;
    logic [2:0] oscSync_r;
    logic [1:0] dinSync_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sclkSync_r <= 3'h0;
            csSync_r   <= 3'h7;
            oscSync_r  <= 3'h0;
            dinSync_r  <= 2'h0;
        end else begin
            sclkSync_r <= {sclkSync_r[1:0], serialClk};
            csSync_r   <= {csSync_r[1:0], chipSel_b};
            oscSync_r  <= {oscSync_r[1:0], conversion_oscillator};
            dinSync_r  <= {dinSync_r[0], serial_in};
        end
    end

    // edges seen on the synchronised copies
    logic sclkRise;
    logic csFall;
    logic csRise;
    logic oscTick;
    logic dIn;
    assign sclkRise = sclkSync_r[1] & ~sclkSync_r[2];
    assign csFall   = ~csSync_r[1] & csSync_r[2];
    assign csRise   = csSync_r[1] & ~csSync_r[2];
    assign oscTick  = oscSync_r[1] & ~oscSync_r[2];
    assign dIn      = dinSync_r[1];

    // ========================================================
    // pair decoding helpers
    function automatic logic pairOk(input logic [PAIR_CFG_W-1:0] pc);
        pairOk = pc[PAIR_EN_BIT] && (pc[1:0] != CFG_INVALID);
    endfunction : pairOk

    // first enabled pair at or after start, wrapping; msb = found
    function automatic logic [2:0] pickPair(input logic [CFG_W-1:0] cfg,
                                            input logic [1:0] start);
        logic [2:0] res;
        logic [1:0] idx;
        res = 3'h0;
        idx = 2'h0;
        for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
            idx = 2'((int'(start) + i) % NUM_PAIRS);
            if (pairOk(cfg[idx*PAIR_CFG_W +: PAIR_CFG_W]))
                res = {1'b1, idx};
        end
        pickPair = res;
    endfunction : pickPair

    // ========================================================
    // registers
    // all sequencing state lives here; the pins only reach it
    // through the synchronised edge strobes and data bit above
    state_t               state_r;
    state_t               state_nxt;
    logic [4:0]           inCnt_r;
    logic [15:0]          inShift_r;
    logic [CFG_W-1:0]     cfg_r;
    logic [1:0]           pair_r;
    logic [4:0]           oscCnt_r;
    logic [OUT_W-1:0]     outShift_r;
    logic [3:0]           outCnt_r;
    logic [RES_W-1:0]     result_r;
    logic [STAT_W-1:0]    status_r;

    // decoded views of the shifted word
    logic [MODE_W-1:0]    modeNow;
    logic [CFG_W-1:0]     cfgIn;
    logic [2:0]           firstPick;
    logic [2:0]           nextPick;
    logic [PAIR_CFG_W-1:0] curCfg;
    logic                 loadOk;
    logic                 startDone;
    logic                 convDone;

    assign modeNow = {inShift_r[2:0], dIn};
    // narrow variant keeps only the lowest pair field
    assign cfgIn = (NUM_PAIRS == 1) ? (inShift_r[CFG_W-1:0] & CFG_NARROW_MASK)
                                    : inShift_r[CFG_W-1:0];
    assign firstPick = pickPair(cfgIn, 2'h0);
    assign nextPick  = pickPair(cfg_r, 2'((int'(pair_r) + 1) % NUM_PAIRS));
    assign curCfg    = cfg_r[pair_r*PAIR_CFG_W +: PAIR_CFG_W];
    // only a complete auto-mode word with a usable pair is loaded
    assign loadOk    = (inCnt_r == IN_BITS)
                    && (inShift_r[15:12] == MODE_AUTO)
                    && firstPick[2];
    assign startDone = oscTick && (oscCnt_r == START_TICKS - 5'h01);
    assign convDone  = oscTick && (oscCnt_r == CONV_TICKS - 5'h01);

    // ========================================================
    // next state
    // any select fall outside the ready and test states restarts the mode word,
    // so a host that lost step always recovers with a fresh command
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (csFall)
                    state_nxt = ST_SHIFT_IN;
            end
            ST_SHIFT_IN: begin
                if (csRise)
                    state_nxt = loadOk ? ST_WAIT : ST_IDLE;
                else if (sclkRise && inCnt_r == MODE_LAST_BIT) begin
                    if (modeNow == MODE_TEST)
                        state_nxt = ST_TEST;
                    else if (modeNow != MODE_AUTO)
                        state_nxt = ST_SKIP_IN;
                end
            end
            ST_SKIP_IN: begin
                if (csRise)
                    state_nxt = ST_IDLE;
            end
            ST_WAIT: begin
                if (csFall)
                    state_nxt = ST_SHIFT_IN;
                else if (startDone)
                    state_nxt = ST_CONVERT;
            end
            ST_CONVERT: begin
                // early select fall is a fresh mode word
                if (csFall)
                    state_nxt = ST_SHIFT_IN;
                else if (convDone)
                    state_nxt = ST_READY;
            end
            ST_READY: begin
                if (csFall)
                    state_nxt = ST_SHIFT_OUT;
            end
            ST_SHIFT_OUT: begin
                if (csRise)
                    state_nxt = ST_WAIT;
            end
            ST_TEST: begin
                state_nxt = ST_TEST;  // only reset leaves
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // ========================================================
    // input word shifter; counter restarts on every select fall
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            inCnt_r   <= 5'h00;
            inShift_r <= 16'h0000;
        end else if (state_r != ST_SHIFT_IN) begin
            inCnt_r <= 5'h00;
        end else if (sclkRise && inCnt_r != IN_BITS) begin
            inShift_r <= {inShift_r[14:0], dIn};
            inCnt_r   <= inCnt_r + 5'h01;
        end
    end

    // ========================================================
    // scan configuration and pair pointer
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cfg_r  <= '0;
            pair_r <= 2'h0;
        end else if (state_r == ST_SHIFT_IN && csRise && loadOk) begin
            cfg_r  <= cfgIn;
            pair_r <= firstPick[1:0];
        end else if (state_r == ST_SHIFT_OUT && csRise) begin
            // disabled pairs are skipped, last one wraps
            pair_r <= nextPick[1:0];
        end
    end

    // ========================================================
    // oscillator period counter, cleared on each state change
    // limitation: the rc oscillator must stay well below a quarter of
    // ref_clk, otherwise ticks are lost in the synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            oscCnt_r <= 5'h00;
        else if (state_nxt != state_r)
            oscCnt_r <= 5'h00;
        else if (oscTick)
            oscCnt_r <= oscCnt_r + 5'h01;
    end

    // ========================================================
    // mux select and sample strobes toward the converter core
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            input_selector <= '0;
            samplePos      <= 1'b0;
            sampleNeg      <= 1'b0;
        end else begin
            input_selector <= {pair_r, curCfg[1:0]};
            samplePos <= (state_r == ST_WAIT) && startDone && !csFall;
            // negative input one oscillator period later
            sampleNeg <= (state_r == ST_CONVERT) && oscTick && !csFall
                      && (oscCnt_r == NEG_TICK) && (curCfg[1:0] == CFG_DIFF);
        end
    end

    // ========================================================
    // end-of-conversion flag; idles high with nothing pending
    // decoded from the next state so the flag falls with the start
    // strobe and rises in the cycle the result is captured
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            endOfConv <= 1'b1;
        else if (state_nxt == ST_CONVERT)
            endOfConv <= 1'b0;
        else
            endOfConv <= 1'b1;
    end

    // ========================================================
    // result capture at the end of each conversion
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            result_r <= '0;
            status_r <= '0;
        end else if (state_r == ST_CONVERT && convDone && !csFall) begin
            result_r <= convResult;  // unsigned code
            status_r <= {pair_r, curCfg[1:0]};
        end
    end

    // ========================================================
    // output shifter; result lsb first, status msb first
    // status bits are reversed at load so one right shift serves both
    // orders; the enable drops on the first surplus clock edge
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            outShift_r  <= '0;
            outCnt_r    <= 4'h0;
            serialOut   <= 1'b0;
            serialOutEn <= 1'b0;
        end else if (state_r == ST_READY && csFall) begin
            outShift_r <= {status_r[0], status_r[1], status_r[2],
                           status_r[3], result_r};
            outCnt_r   <= 4'h0;
        end else if (state_r == ST_SHIFT_OUT && !csRise) begin
            if (sclkRise && outCnt_r != OUT_BITS) begin
                serialOut   <= outShift_r[0];
                serialOutEn <= 1'b1;
                outShift_r  <= {1'b0, outShift_r[OUT_W-1:1]};
                outCnt_r    <= outCnt_r + 4'h1;
            end else if (sclkRise) begin
                serialOutEn <= 1'b0;
            end
        end else begin
            // released while words are shifted in, so pins may share
            serialOutEn <= 1'b0;
        end
    end

    // ========================================================
    // test-mode indicator
    // only rst_b clears it, standing in for a power cycle of the part
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            testModeLock <= 1'b0;
        else
            testModeLock <= (state_nxt == ST_TEST);
    end

endmodule : auto_scan_adc_serial_sequencer

// file: auto_scan_adc_serial_sequencer_tb.sv
// self-checking bench for the auto-scan serial sequencer
// assumes: host model owns the link, bench owns oscillator and result
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    nChecks++; \
    if ((got) !== (exp)) begin \
        errTotal++; \
        $display("unexpected %0t got %h exp %h", $time, (got), (exp)); \
    end \
end
module auto_scan_adc_serial_sequencer_tb;
    import scan_seq_pkg::*;

    // ========================================================
    // pins and bookkeeping
    logic              ref_clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              conversion_oscillator = 1'b0;
    logic [RES_W-1:0]  convResult = 8'h00;
    logic              serialClk, chipSel_b, serial_in, serialOut;
    logic              serialOutEn, endOfConv, samplePos, sampleNeg;
    logic              testModeLock;
    logic [STAT_W-1:0] input_selector;
    logic [11:0]       cfg;
    int                errTotal = 0;
    int                nChecks = 0;
    int                cycles = 0;
    integer            seed = 32'h7517;

    always #20 ref_clk = ~ref_clk;
    // oscillator phase kept unrelated to the system clock
    initial begin
        #137;
        forever #500 conversion_oscillator = ~conversion_oscillator;
    end

    // fresh result per conversion, stable until it is read
    always @(posedge ref_clk) if (samplePos) convResult <= 8'($random(seed));

    // hang guard, well above the expected run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errTotal++;
            final_report();
        end
    end

    auto_scan_adc_serial_sequencer #(.NUM_PAIRS(4)) auto_scan_adc_serial_sequencer_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .serialClk(serialClk),
        .chipSel_b(chipSel_b), .serial_in(serial_in), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .endOfConv(endOfConv),
        .conversion_oscillator(conversion_oscillator),
        .convResult(convResult), .input_selector(input_selector),
        .samplePos(samplePos), .sampleNeg(sampleNeg),
        .testModeLock(testModeLock));
    scan_host scan_host_i (
        .ref_clk(ref_clk), .serialClk(serialClk), .chipSel_b(chipSel_b),
        .serial_in(serial_in), .serialOut(serialOut),
        .serialOutEn(serialOutEn));

    // ========================================================
    // expectations: next enabled valid pair, wrapping round
    function automatic int next_pair(input logic [11:0] c, input int cur);
        int p;
        for (int k = 1; k <= MAX_PAIRS; k++) begin
            p = (cur + k) % MAX_PAIRS;
            if (c[3*p+2] && c[3*p+:2] != CFG_INVALID) return p;
        end
        return -1;
    endfunction : next_pair

    task automatic final_report;
        if (errTotal == 0 && nChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic wait_eoc(input logic v);
        int i;
        i = 0;
        while (endOfConv !== v && i < 3000) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        `CHK(endOfConv, v)
    endtask : wait_eoc

    // longer than the two-period start bound
    task automatic settle;
        repeat (100) @(posedge ref_clk);
        #1;
    endtask : settle

    // load a word with trailing junk bits, then five reads to wrap
    task automatic run_scan(input logic [11:0] c, input bit holdLow);
        int p;
        logic [11:0] d;
        logic en;
        logic [3:0] s;
        p = next_pair(c, MAX_PAIRS - 1);
        scan_host_i.send_word({MODE_AUTO, c, 4'($random(seed))}, 20);
        for (int r = 0; r < 5; r++) begin
            s = {2'(p), c[3*p+:2]};
            wait_eoc(1'b0);
            `CHK(input_selector, s)
            wait_eoc(1'b1);
            scan_host_i.read_word(13, d, en);
            `CHK(d, {s[0], s[1], s[2], s[3], convResult})
            `CHK(en, 1'b0)
            p = next_pair(c, p);
        end
        if (holdLow) wait_eoc(1'b0);
    endtask : run_scan

    // ========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        scan_host_i.send_word({4'ha, 12'h9d5, 4'h0}, 16);
        settle();
        `CHK(endOfConv, 1'b1)
        scan_host_i.send_word({MODE_AUTO, 12'h9d5, 4'h0}, 10);
        settle();
        `CHK(endOfConv, 1'b1)
        for (int t = 0; t < 4; t++) begin
            cfg = (t == 0) ? 12'h9d5 : 12'($random(seed));
            if (next_pair(cfg, MAX_PAIRS - 1) < 0) cfg[2:0] = 3'h4;
            run_scan(cfg, t[0]);
        end
        scan_host_i.send_word({MODE_TEST, 12'h9d5, 4'h0}, 16);
        settle();
        `CHK(testModeLock, 1'b1)
        scan_host_i.send_word({MODE_AUTO, 12'h9d5, 4'h0}, 16);
        settle();
        `CHK(endOfConv, 1'b1)
        final_report();
    end
endmodule : auto_scan_adc_serial_sequencer_tb

// file: scan_host.sv
// host model of the serial link, driven by bench task calls
// assumes: ref_clk only paces the link, 320 ns a link period
`timescale 1ns/1ps
module scan_host (
    // pacing clock
    input  wire logic ref_clk,
    // link pins driven by the host
    output logic      serialClk,
    output logic      chipSel_b,
    output logic      serial_in,
    // link pins driven by the device
    input  wire logic serialOut,
    input  wire logic serialOutEn
);
    // ========================================================
    // idle link: clock still, select high, data line never settles
    initial begin
        serialClk = 1'b0;
        chipSel_b = 1'b1;
        serial_in = 1'b0;
    end

    always @(posedge ref_clk) if (chipSel_b) serial_in <= ~serial_in;

    // half a link period
    task automatic half;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : half

    // word msb first, bit set while the link clock is low
    task automatic send_word(input logic [19:0] w, input int n);
        half();
        chipSel_b = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in = w[19-i];
            half();
            serialClk = 1'b1;
            half();
            serialClk = 1'b0;
        end
        half();
        chipSel_b = 1'b1;
    endtask : send_word

    // read n bits; a bit seen with the output released reads as unknown
    task automatic read_word(input int n, output logic [11:0] d,
                             output logic en);
        d = 12'h000;
        en = 1'b0;
        half();
        chipSel_b = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in = ~serial_in;
            half();
            serialClk = 1'b1;
            half();
            if (i < 12) d[i] = serialOutEn ? serialOut : 1'bx;
            en = serialOutEn;
            serialClk = 1'b0;
        end
        half();
        chipSel_b = 1'b1;
    endtask : read_word
endmodule : scan_host

// file: scan_seq_pkg.sv
// constants and state type for the auto-scan serial sequencer
// assumes: shared by the sequencer module, its bench and its checker
package scan_seq_pkg;

    // ========================================================
    // word layout
    localparam int MODE_W     = 4;
    localparam int CFG_W      = 12;
    localparam int PAIR_CFG_W = 3;
    localparam int RES_W      = 8;
    localparam int STAT_W     = 4;
    localparam int OUT_W      = RES_W + STAT_W;
    localparam int MAX_PAIRS  = CFG_W / PAIR_CFG_W;

    // ========================================================
    // mode codes and per-pair field coding
    localparam logic [MODE_W-1:0] MODE_AUTO    = 4'he;
    localparam logic [MODE_W-1:0] MODE_TEST    = 4'hc;
    localparam int                PAIR_EN_BIT  = 2;
    localparam logic [1:0]        CFG_DIFF     = 2'h1;
    localparam logic [1:0]        CFG_INVALID  = 2'h3;
    localparam logic [CFG_W-1:0]  CFG_NARROW_MASK = 12'h007;

    // ========================================================
    // bit counts of the serial words
    localparam logic [4:0] MODE_LAST_BIT = 5'h03;
    localparam logic [4:0] IN_BITS       = 5'h10;
    localparam logic [3:0] OUT_BITS      = 4'hc;

    // ========================================================
    // timing, counted in conversion oscillator periods; nominal period in ns
    localparam logic [4:0] START_TICKS = 5'h02;
    localparam logic [4:0] CONV_TICKS  = 5'h11;
    localparam logic [4:0] NEG_TICK    = 5'h00;
    localparam int         NOM_OSC_PERIOD_NS = 1000;

    // ========================================================
    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE      = 8'h01,
        ST_SHIFT_IN  = 8'h02,
        ST_SKIP_IN   = 8'h04,
        ST_WAIT      = 8'h08,
        ST_CONVERT   = 8'h10,
        ST_READY     = 8'h20,
        ST_SHIFT_OUT = 8'h40,
        ST_TEST      = 8'h80
    } state_t;

endpackage : scan_seq_pkg

// file: scan_seq_properties.sv
// checker for the auto-scan serial sequencer, bound onto its top
// assumes: bench oscillator near 25 system clocks a period
`timescale 1ns/1ps
module scan_seq_properties #(
    parameter int NUM_PAIRS = 4
) (
    // clock and reset
    input wire logic                            ref_clk,
    input wire logic                            rst_b,
    // link and oscillator pins
    input wire logic                            chipSel_b,
    input wire logic                            serialOutEn,
    input wire logic                            endOfConv,
    input wire logic                            conversion_oscillator,
    // converter core side
    input wire logic [scan_seq_pkg::STAT_W-1:0] input_selector,
    input wire logic                            samplePos,
    input wire logic                            sampleNeg,
    input wire logic                            testModeLock
);
    import scan_seq_pkg::*;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ========================================================
    // helper counters; osc pin is async, so two flops before edge find
    logic [2:0] oscSync_r;
    logic [4:0] oscCnt_r;
    logic [7:0] selHigh_r;
    logic [7:0] sincePos_r;
    logic       aborted_r;

    always_ff @(posedge ref_clk) begin
        oscSync_r <= {oscSync_r[1:0], conversion_oscillator};
        if (!rst_b) begin
            selHigh_r  <= 8'h00;
            sincePos_r <= 8'hff;
            oscCnt_r   <= 5'h00;
            aborted_r  <= 1'b0;
        end else begin
            selHigh_r  <= chipSel_b ? selHigh_r + 8'(selHigh_r != 8'hff) : 8'h00;
            sincePos_r <= samplePos ? 8'h00 : sincePos_r + 8'(sincePos_r != 8'hff);
            // counts only while converting, cleared once the flag is high
            if (endOfConv)
                oscCnt_r <= 5'h00;
            else if (oscSync_r[1] && !oscSync_r[2])
                oscCnt_r <= oscCnt_r + 5'h01;
            // an aborted conversion ends early, so length is not judged
            if (samplePos)
                aborted_r <= 1'b0;
            else if (!endOfConv && !chipSel_b)
                aborted_r <= 1'b1;
        end
    end

    // ========================================================
    // assertions
    a_start_win: assert property ($fell(endOfConv) |->
        selHigh_r inside {[16:64]}) else $error("start delay off");
    a_start_pulse: assert property (samplePos |->
        ##[0:2] !endOfConv) else $error("no busy flag at start");
    a_conv_len: assert property ($rose(endOfConv) && !aborted_r |->
        oscCnt_r inside {[16:18]}) else $error("conversion length off");
    a_neg_spacing: assert property (sampleNeg |->
        sincePos_r inside {[18:32]} && input_selector[1:0] == CFG_DIFF)
        else $error("minus sample misplaced");
    a_pair_valid: assert property (samplePos |->
        ##1 input_selector[1:0] != CFG_INVALID) else $error("invalid pair");
    a_pair_range: assert property (samplePos |->
        ##1 int'(input_selector[3:2]) < NUM_PAIRS) else $error("pair range");
    a_out_release: assert property ($rose(chipSel_b) |->
        ##[1:5] !serialOutEn) else $error("output kept after deselect");
    a_out_quiet: assert property (!endOfConv |->
        !serialOutEn) else $error("output driven while converting");
    a_lock_sticky: assert property (testModeLock |=>
        testModeLock && !samplePos) else $error("test lock left");

    // main scenarios seen
    c_diff: cover property (sampleNeg);
    c_done: cover property ($rose(endOfConv) && !aborted_r);
    c_lock: cover property ($rose(testModeLock));
endmodule : scan_seq_properties

bind auto_scan_adc_serial_sequencer scan_seq_properties #(
    .NUM_PAIRS(NUM_PAIRS)
) scan_seq_properties_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .chipSel_b(chipSel_b),
    .serialOutEn(serialOutEn), .endOfConv(endOfConv),
    .conversion_oscillator(conversion_oscillator),
    .input_selector(input_selector), .samplePos(samplePos),
    .sampleNeg(sampleNeg), .testModeLock(testModeLock)
);
